// *** fbm_pkg.sv ***
// fieldbus master controller: shared constants, types and register map
// assumes one 25 MHz clock domain for bus, frame transmit and receive
`default_nettype none

package fbm_pkg;

    // ========================================================
    // frame layout (byte positions within an outgoing frame)
    localparam logic [15:0] ETH_TYPE_FB = 16'h88a4;
    localparam logic [3:0] FB_HDR_TYPE = 4'h1;
    localparam logic [47:0] MAC_DST = 48'hffffffffffff;
    localparam logic [47:0] MAC_SRC = 48'h020000000001; // arbitrary value
    localparam logic [5:0] POS_SRC = 6'h06;
    localparam logic [5:0] POS_TYPE = 6'h0c;
    localparam logic [5:0] POS_FBH = 6'h0e;
    localparam logic [5:0] POS_CMD = 6'h10;
    localparam logic [5:0] POS_ADP = 6'h12;
    localparam logic [5:0] POS_ADO = 6'h14;
    localparam logic [5:0] POS_LEN = 6'h16;
    localparam logic [5:0] POS_DATA = 6'h1a;
    localparam logic [5:0] POS_MAX = 6'h3f;
    localparam logic [10:0] TEL_HDR_LEN = 11'h00a;
    localparam logic [10:0] WKC_LEN = 11'h002;
    localparam logic [2:0] LEN_MAX = 3'h4;

    // ========================================================
    // own register offsets (byte addresses on the bus)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SVC = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_NODE = 8'h0c;
    localparam logic [7:0] REG_LEN = 8'h10;
    localparam logic [7:0] REG_WDATA = 8'h14;
    localparam logic [7:0] REG_RDATA = 8'h18;
    localparam logic [7:0] REG_WKC = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_ESM = 8'h24;
    localparam logic [7:0] REG_ASSIGN = 8'h28;
    localparam logic [7:0] REG_MAPSEL = 8'h2c;
    localparam int CTRL_START = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_WKC_ZERO = 3;

    // ========================================================
    // object directory indices seen by the master
    localparam logic [15:0] OBJ_DEVICE_TYPE = 16'h1000;
    localparam logic [15:0] OBJ_TXMAP_FIRST = 16'h1a00;
    localparam logic [15:0] OBJ_TXMAP_LAST = 16'h1a27;
    localparam logic [15:0] OBJ_TX_ASSIGN = 16'h1c13;
    localparam logic [15:0] OBJ_MEAS_ENABLE = 16'h21b0;

    // ========================================================
    // types
    typedef enum logic [7:0] {
        SVC_APRD = 8'h01, SVC_APWR = 8'h02, SVC_APRW = 8'h03,
        SVC_FPRD = 8'h04, SVC_FPWR = 8'h05, SVC_FPRW = 8'h06,
        SVC_BRD = 8'h07, SVC_BWR = 8'h08, SVC_LRD = 8'h0a,
        SVC_LWR = 8'h0b, SVC_LRW = 8'h0c, SVC_ARMW = 8'h0d,
        SVC_FRMW = 8'h0e
    } fbm_svc_e;

    typedef enum logic [1:0] {
        FSM_IDLE = 2'h0, FSM_SEND = 2'h1, FSM_WAIT = 2'h3, FSM_DONE = 2'h2
    } fbm_fsm_e;

    typedef enum logic [3:0] {
        ESM_INIT = 4'h1, ESM_PREOP = 4'h2, ESM_SAFEOP = 4'h4, ESM_OP = 4'h8
    } fbm_esm_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fbm_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fbm_apb_rsp_s;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
        logic last;
    } fbm_byte_s;

    typedef struct packed {
        logic [7:0] svc;
        logic [7:0] idx;
        logic [15:0] adp;
        logic [15:0] ado;
        logic [2:0] len;
        logic [31:0] wdata;
    } fbm_tel_s;

    // mapping entry: index 31..16, subindex 15..8, length in bits 7..0
    typedef struct packed {
        logic [15:0] index;
        logic [7:0] sub;
        logic [7:0] bits;
    } fbm_map_s;

endpackage : fbm_pkg

`default_nettype wire

// *** fbm_tx_byte.sv ***
// fieldbus master: byte picker for one outgoing single-telegram frame
// assumes the caller walks i_pos from zero and registers the result
`default_nettype none

module fbm_tx_byte
    import fbm_pkg::*;
(
    input wire logic [5:0] i_pos,
    input wire fbm_tel_s i_tel,
    output logic [7:0] o_byte,
    output logic o_last
);

    // ========================================================
    // helpers
    function automatic logic [7:0] mac_byte(input logic [47:0] m,
                                            input logic [2:0] k);
        logic [5:0] b;
        b = 6'(6'h2f - {k, 3'h0});
        return m[b -: 8];
    endfunction : mac_byte

    logic [10:0] tlen;
    logic [5:0] rel;
    logic [5:0] data_end;

    assign tlen = TEL_HDR_LEN + 11'(i_tel.len) + WKC_LEN;
    assign rel = i_pos - POS_DATA;
    assign data_end = POS_DATA + 6'(i_tel.len);

    // ========================================================
    // frame byte selection; telegram fields go out low byte first
    always_comb begin
        o_last = (i_pos == data_end + 6'h01);
        o_byte = 8'h00;
        if (i_pos < POS_SRC) begin
            o_byte = mac_byte(MAC_DST, i_pos[2:0]);
        end else if (i_pos < POS_TYPE) begin
            o_byte = mac_byte(MAC_SRC, 3'(i_pos - POS_SRC));
        end else if (i_pos == POS_TYPE) begin
            o_byte = ETH_TYPE_FB[15:8];
        end else if (i_pos == POS_TYPE + 6'h01) begin
            o_byte = ETH_TYPE_FB[7:0];
        end else if (i_pos == POS_FBH) begin
            o_byte = tlen[7:0];
        end else if (i_pos == POS_FBH + 6'h01) begin
            o_byte = {FB_HDR_TYPE, 1'b0, tlen[10:8]};
        end else if (i_pos == POS_CMD) begin
            o_byte = i_tel.svc;
        end else if (i_pos == POS_CMD + 6'h01) begin
            o_byte = i_tel.idx;
        end else if (i_pos == POS_ADP) begin
            o_byte = i_tel.adp[7:0];
        end else if (i_pos == POS_ADP + 6'h01) begin
            o_byte = i_tel.adp[15:8];
        end else if (i_pos == POS_ADO) begin
            o_byte = i_tel.ado[7:0];
        end else if (i_pos == POS_ADO + 6'h01) begin
            o_byte = i_tel.ado[15:8];
        end else if (i_pos == POS_LEN) begin
            o_byte = {5'h00, i_tel.len};
        end else if (i_pos >= POS_DATA && i_pos < data_end) begin
            o_byte = i_tel.wdata[{rel[1:0], 3'h0} +: 8];
        end
        // header tail, interrupt word and working counter go out as zero
    end

endmodule : fbm_tx_byte

`default_nettype wire

// *** fbm_rx_parse.sv ***
// fieldbus master: parser for the returning single-telegram frame
// assumes the receive byte stream runs on the controller clock
`default_nettype none

module fbm_rx_parse
    import fbm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire fbm_byte_s i_rx,
    input wire logic [2:0] i_len,
    output logic o_done,
    output logic o_type_ok,
    output logic [31:0] o_rdata,
    output logic [15:0] o_wkc
);

    typedef struct packed {
        logic [5:0] pos;
        logic hi_ok;
        logic type_ok;
        logic [31:0] rdata;
        logic [15:0] wkc;
        logic done;
    } fbm_rx_st_s;

    fbm_rx_st_s s_q;
    fbm_rx_st_s s_d;
    logic [5:0] rel;
    logic [5:0] data_end;

    assign rel = s_q.pos - POS_DATA;
    assign data_end = POS_DATA + 6'(i_len);

    // ========================================================
    // byte walk; frames of another type never raise type_ok
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (i_rx.valid) begin
            if (s_q.pos == POS_TYPE) begin
                s_d.hi_ok = (i_rx.data == ETH_TYPE_FB[15:8]);
            end else if (s_q.pos == POS_TYPE + 6'h01) begin
                s_d.type_ok = s_q.hi_ok
                    && (i_rx.data == ETH_TYPE_FB[7:0]);
            end else if (s_q.pos >= POS_DATA && s_q.pos < data_end) begin
                s_d.rdata[{rel[1:0], 3'h0} +: 8] = i_rx.data;
            end else if (s_q.pos == data_end) begin
                s_d.wkc[7:0] = i_rx.data;
            end else if (s_q.pos == data_end + 6'h01) begin
                s_d.wkc[15:8] = i_rx.data;
            end
            // saturate so an overlong frame cannot wrap into the header
            if (s_q.pos != POS_MAX) begin
                s_d.pos = s_q.pos + 6'h01;
            end
            if (i_rx.last) begin
                s_d.done = 1'b1;
                s_d.pos = 6'h00;
                s_d.hi_ok = 1'b0;
            end
        end
        if (s_q.done) begin
            s_d.type_ok = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_done = s_q.done;
    assign o_type_ok = s_q.type_ok;
    assign o_rdata = s_q.rdata;
    assign o_wkc = s_q.wkc;

endmodule : fbm_rx_parse

`default_nettype wire

// *** fbm_master_ctl.sv ***
// fieldbus master controller: software issues one telegram per frame
// through an APB register block, sees returned data and working counter
// assumes the MAC accepts bytes with valid/ready and adds preamble/FCS
//
// Chosen here: the APB interface to the registers.
`default_nettype none

module fbm_master_ctl
    import fbm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire fbm_apb_req_s i_apb,
    output var fbm_apb_rsp_s o_apb,
    output var fbm_byte_s o_tx,
    input wire logic i_tx_ready,
    input wire fbm_byte_s i_rx
);

    // ========================================================
    // state record
    typedef struct packed {
        fbm_fsm_e fsm;
        fbm_apb_rsp_s rsp;
        fbm_byte_s tx;

        logic [5:0] pos;

        fbm_tel_s cfg;
        fbm_tel_s tel;

        logic [15:0] node;
        logic [31:0] rdata;
        logic [15:0] wkc;
        logic done;
        logic refused;

        fbm_esm_e esm;
        logic [15:0] assign_idx;
        fbm_map_s map;
    } fbm_ctl_st_s;

    fbm_ctl_st_s s_q;
    fbm_ctl_st_s s_d;

    // picker and parser results
    logic [7:0] tx_byte;
    logic tx_last;
    logic rx_done;
    logic rx_type_ok;
    logic [31:0] rx_rdata;
    logic [15:0] rx_wkc;

    // ========================================================
    // decode helpers
    // aligned words only
    function automatic logic is_mapped(input logic [7:0] a);
        if (a == REG_CTRL) return 1'b1;
        else if (a == REG_SVC) return 1'b1;
        else if (a == REG_ADDR) return 1'b1;
        else if (a == REG_NODE) return 1'b1;
        else if (a == REG_LEN) return 1'b1;
        else if (a == REG_WDATA) return 1'b1;
        else if (a == REG_RDATA) return 1'b1;
        else if (a == REG_WKC) return 1'b1;
        else if (a == REG_STATUS) return 1'b1;
        else if (a == REG_ESM) return 1'b1;
        else if (a == REG_ASSIGN) return 1'b1;
        else if (a == REG_MAPSEL) return 1'b1;
        else return 1'b0;
    endfunction : is_mapped

    // logical services move process data
    function automatic logic is_logical(input logic [7:0] svc);
        return svc == SVC_LRD || svc == SVC_LWR || svc == SVC_LRW;
    endfunction : is_logical

    // fixed-address services take the node address
    function automatic logic is_fixed(input logic [7:0] svc);
        return svc == SVC_FPRD || svc == SVC_FPWR
            || svc == SVC_FPRW || svc == SVC_FRMW;
    endfunction : is_fixed

    // ========================================================
    // frame byte picker and return-frame parser
    fbm_tx_byte u_tx_byte (
        .i_pos (s_q.pos),
        .i_tel (s_q.tel),
        .o_byte (tx_byte),
        .o_last (tx_last)
    );

    // parser runs always; the wait state picks
    fbm_rx_parse u_rx_parse (
        .i_clk_sys (i_clk_sys),
        .i_rst_n (i_rst_n),
        .i_ce (i_ce),
        .i_rx (i_rx),
        .i_len (s_q.tel.len),
        .o_done (rx_done),
        .o_type_ok (rx_type_ok),
        .o_rdata (rx_rdata),
        .o_wkc (rx_wkc)
    );

    // ========================================================
    // next-state logic: bus slave, then registers, then sequencer
    // comb block helpers
    logic wr;
    logic start;
    logic [31:0] rd_val;
    logic [31:0] st_word;

    always_comb begin
        s_d = s_q;

        start = 1'b0;
        wr = i_apb.psel && i_apb.penable && i_apb.pwrite && s_q.rsp.pready;

        // status word for reads
        st_word = '0;
        st_word[ST_BUSY] = (s_q.fsm != FSM_IDLE);
        st_word[ST_DONE] = s_q.done;
        st_word[ST_REFUSED] = s_q.refused;
        st_word[ST_WKC_ZERO] = (s_q.wkc == 16'h0000);

        // read mux, sampled in the setup cycle
        rd_val = '0;
        if (i_apb.paddr == REG_SVC) begin
            rd_val = {16'h0000, s_q.cfg.idx, s_q.cfg.svc};
        end else if (i_apb.paddr == REG_ADDR) begin
            rd_val = {s_q.cfg.ado, s_q.cfg.adp};
        end else if (i_apb.paddr == REG_NODE) begin
            rd_val = {16'h0000, s_q.node};
        end else if (i_apb.paddr == REG_LEN) begin
            rd_val = {29'h0, s_q.cfg.len};
        end else if (i_apb.paddr == REG_WDATA) begin
            rd_val = s_q.cfg.wdata;
        end else if (i_apb.paddr == REG_RDATA) begin
            rd_val = s_q.rdata;
        end else if (i_apb.paddr == REG_WKC) begin
            rd_val = {16'h0000, s_q.wkc};
        end else if (i_apb.paddr == REG_STATUS) begin
            rd_val = st_word;
        end else if (i_apb.paddr == REG_ESM) begin
            rd_val = {28'h0, s_q.esm};
        end else if (i_apb.paddr == REG_ASSIGN) begin
            rd_val = {16'h0000, s_q.assign_idx};
        end else if (i_apb.paddr == REG_MAPSEL) begin
            rd_val = s_q.map;
        end

        // zero-wait slave: ready registered from the setup cycle
        s_d.rsp.pready = i_apb.psel && !i_apb.penable;
        // error stands beside ready only
        s_d.rsp.pslverr = 1'b0;
        if (i_apb.psel && !i_apb.penable) begin
            s_d.rsp.prdata = i_apb.pwrite ? 32'h0 : rd_val;
            s_d.rsp.pslverr = !is_mapped(i_apb.paddr);
        end

        // register writes take effect in the access phase only
        if (wr) begin
            if (i_apb.paddr == REG_CTRL) begin
                // pulse; ignored unless idle
                start = i_apb.pwdata[CTRL_START];
            end else if (i_apb.paddr == REG_SVC) begin
                s_d.cfg.svc = i_apb.pwdata[7:0];
                s_d.cfg.idx = i_apb.pwdata[15:8];
            end else if (i_apb.paddr == REG_ADDR) begin
                s_d.cfg.adp = i_apb.pwdata[15:0];
                s_d.cfg.ado = i_apb.pwdata[31:16];
            end else if (i_apb.paddr == REG_NODE) begin
                s_d.node = i_apb.pwdata[15:0];
            end else if (i_apb.paddr == REG_LEN) begin
                // the single-word data area caps the telegram length
                s_d.cfg.len = (i_apb.pwdata[31:0] > 32'(LEN_MAX))
                    ? LEN_MAX : i_apb.pwdata[2:0];
            end else if (i_apb.paddr == REG_WDATA) begin
                s_d.cfg.wdata = i_apb.pwdata;
            end else if (i_apb.paddr == REG_STATUS) begin
                // W1C; a set in the same cycle wins
                if (i_apb.pwdata[ST_DONE]) s_d.done = 1'b0;
                if (i_apb.pwdata[ST_REFUSED]) s_d.refused = 1'b0;
            end else if (i_apb.paddr == REG_ESM) begin
                // software owns this view
                s_d.esm = fbm_esm_e'(i_apb.pwdata[3:0]);
            end else if (i_apb.paddr == REG_ASSIGN) begin
                if (s_q.esm == ESM_PREOP) begin
                    s_d.assign_idx = i_apb.pwdata[15:0];
                end else begin
                    s_d.refused = 1'b1;
                end
            end else if (i_apb.paddr == REG_MAPSEL) begin
                // mapping objects are never targeted directly
                if (i_apb.pwdata[31:16] >= OBJ_TXMAP_FIRST
                        && i_apb.pwdata[31:16] <= OBJ_TXMAP_LAST) begin
                    s_d.refused = 1'b1;
                end else begin
                    s_d.map = i_apb.pwdata;
                end
            end
        end

        // telegram sequencer
        case (s_q.fsm)
            FSM_IDLE: begin
                if (start) begin
                    // process data only once inputs are exchanged
                    if (is_logical(s_q.cfg.svc) && s_q.esm != ESM_SAFEOP
                            && s_q.esm != ESM_OP) begin
                        s_d.refused = 1'b1;
                    end else begin
                        s_d.tel = s_q.cfg;
                        if (is_fixed(s_q.cfg.svc)) begin
                            s_d.tel.adp = s_q.node;
                        end
                        // walk from byte zero
                        s_d.pos = '0;
                        s_d.fsm = FSM_SEND;
                    end
                end
            end
            FSM_SEND: begin
                if (s_q.tx.valid && i_tx_ready && s_q.tx.last) begin
                    // stream released
                    s_d.tx.valid = 1'b0;
                    s_d.tx.last = 1'b0;
                    s_d.fsm = FSM_WAIT;
                end else if (!s_q.tx.valid || i_tx_ready) begin
                    // stream stalls on ready; byte held until taken
                    s_d.tx.data = tx_byte;
                    s_d.tx.valid = 1'b1;
                    s_d.tx.last = tx_last;
                    s_d.pos = s_q.pos + 6'h01;
                end
            end
            FSM_WAIT: begin
                // foreign frames are skipped; the wait has no timeout
                if (rx_done && rx_type_ok) begin
                    // latched as slaves left them
                    s_d.rdata = rx_rdata;
                    s_d.wkc = rx_wkc;
                    s_d.done = 1'b1;
                    s_d.fsm = FSM_DONE;
                end
            end
            FSM_DONE: begin
                // busy drops next cycle
                s_d.fsm = FSM_IDLE;
            end
            default: begin
                // corrupted state
                s_d.fsm = FSM_IDLE;
            end
        endcase
    end

    // ========================================================
    // state register; clock enable low freezes everything
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
            // values software reads first
            s_q.fsm <= FSM_IDLE;
            s_q.esm <= ESM_INIT; // slave comes up in Initialization
            s_q.cfg.len <= LEN_MAX;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign o_apb = s_q.rsp;
    assign o_tx = s_q.tx;

endmodule : fbm_master_ctl

`default_nettype wire

// *** fbm_mc_properties.sv ***
// checker: port-level properties of the fieldbus master controller
// assumes a single clock domain and i_ce held high by the bench
`default_nettype none

module fbm_mc_properties
    import fbm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire fbm_apb_req_s i_apb,
    input wire fbm_apb_rsp_s o_apb,
    input wire fbm_byte_s o_tx,
    input wire logic i_tx_ready,
    input wire fbm_byte_s i_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic [5:0] pos_q;
    wire logic tk = o_tx.valid && i_tx_ready;
    wire logic setup = i_apb.psel && !i_apb.penable;
    // ==========================================================
    // byte position; a frame restarts the count at its last byte
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) pos_q <= 6'h00;
        else if (tk) pos_q <= o_tx.last ? 6'h00 : pos_q + 6'h01;
    end
    // ==========================================================
    // bus answer and frame shape
    property p_rdy; setup |=> o_apb.pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_one; o_apb.pready |=> !o_apb.pready; endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_err; o_apb.pslverr |-> o_apb.pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_bad; setup && i_apb.paddr > 8'h2c |=> o_apb.pslverr;
    endproperty
    a_bad: assert property (p_bad) else $error("unmapped not flagged");
    property p_hold;
        o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx.data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_end; tk && o_tx.last |-> o_tx.data == 8'h00 ##1 !o_tx.valid;
    endproperty
    a_end: assert property (p_end) else $error("bad frame end");
    property p_dst; o_tx.valid && pos_q < POS_SRC |-> o_tx.data == 8'hff;
    endproperty
    a_dst: assert property (p_dst) else $error("bad dest");
    property p_type;
        o_tx.valid && pos_q[5:1] == POS_TYPE[5:1]
            |-> o_tx.data == (pos_q[0] ? 8'ha4 : 8'h88);
    endproperty
    a_type: assert property (p_type) else $error("bad type");
    c_frame: cover property (tk && o_tx.last);
    c_stall: cover property (o_tx.valid && !i_tx_ready);
    c_slverr: cover property (o_apb.pslverr);
endmodule : fbm_mc_properties

bind fbm_master_ctl fbm_mc_properties chk_u (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_apb(i_apb), .o_apb(o_apb),
    .o_tx(o_tx), .i_tx_ready(i_tx_ready), .i_rx(i_rx));

`default_nettype wire

// *** fbm_slave_model.sv ***
// behavioural slave on the segment: takes a frame, answers it
// assumes one telegram per frame, bytes on the controller clock
`default_nettype none

module fbm_slave_model
    import fbm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_slow,
    input wire fbm_byte_s i_tx,
    output logic o_tx_ready,
    output fbm_byte_s o_rx,
    output logic [15:0] o_adp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] buf_q [64];
    int n = 0;
    // ==========================================================
    // answer: read data supplied, counter bumped; gaps when slow
    task automatic reply();
        int len;
        len = int'(buf_q[22][2:0]);
        @(posedge i_clk_sys);
        o_adp <= {buf_q[19], buf_q[18]};
        if ({buf_q[12], buf_q[13]} == ETH_TYPE_FB) begin
            for (int k = 0; k < len; k++)
                buf_q[26 + k] ^= 8'h5a;
            buf_q[26 + len] += 8'h01;
            for (int k = 0; k < n; k++) begin
                if (i_slow) begin
                    o_rx <= '{~o_rx.data, 1'b0, 1'b0};
                    @(posedge i_clk_sys);
                end
                o_rx <= '{buf_q[k], 1'b1, k == n - 1};
                @(posedge i_clk_sys);
            end
            o_rx <= '{~buf_q[n - 1], 1'b0, 1'b0};
        end
        n = 0;
    endtask : reply
    // collect bytes; a slow peer stalls every other cycle
    initial begin
        o_rx = '0;
        o_tx_ready = 1'b1;
        o_adp = '0;
        forever begin
            @(posedge i_clk_sys);
            if (i_tx.valid && o_tx_ready) begin
                buf_q[n] = i_tx.data;
                n++;
                if (i_tx.last) reply();
            end
            o_tx_ready <= !i_slow || !o_tx_ready;
        end
    end
endmodule : fbm_slave_model

`default_nettype wire

// *** tb_top.sv ***
// testbench: registers over apb, one frame per service code
// assumes the slave model answers every frame it recognises
`default_nettype none

module tb_top
    import fbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic slow = 1'b0;
    logic rdy;
    logic e;
    logic [31:0] r;
    logic [15:0] adp;
    logic [15:0] node = 16'h0000;
    fbm_apb_req_s apb = '0;
    fbm_apb_rsp_s rsp;
    fbm_byte_s tx;
    fbm_byte_s rx;
    int miscompares = 0;
    int compares = 0;
    integer seed = 84;
    logic [7:0] svcs [13] = '{SVC_APRD, SVC_APWR, SVC_APRW, SVC_FPRD,
        SVC_FPWR, SVC_FPRW, SVC_BRD, SVC_BWR, SVC_LRD, SVC_LWR, SVC_LRW,
        SVC_ARMW, SVC_FRMW};
    // ==========================================================
    // clock, design and far-side peer
    initial forever #20 i_clk_sys = ~i_clk_sys;
    fbm_master_ctl dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_ce(1'b1), .i_apb(apb), .o_apb(rsp), .o_tx(tx),
        .i_tx_ready(rdy), .i_rx(rx));
    fbm_slave_model peer_u (.i_clk_sys(i_clk_sys), .i_slow(slow),
        .i_tx(tx), .o_tx_ready(rdy), .o_rx(rx), .o_adp(adp));
    // ==========================================================
    // helpers
    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] x, g);
        compares++;
        if (g !== x) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, x, g);
        end
    endtask : chk
    // one apb transfer; an idle cycle follows so strobes never collide
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_clk_sys);
        apb.penable <= 1'b1;
        do @(posedge i_clk_sys); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        e = rsp.pslverr;
        apb <= '0;
        @(posedge i_clk_sys);
    endtask : bus
    function automatic logic [31:0] msk(input logic [2:0] l);
        msk = (32'h1 << (l * 8)) - 32'h1;
    endfunction : msk
    // one frame: send, poll done, check answer and address used
    task automatic run(input logic [7:0] s, input logic [2:0] l,
                       input logic [31:0] w);
        int k;
        bus(1'b1, REG_SVC, {24'h0, s});
        bus(1'b1, REG_LEN, {29'h0, l});
        bus(1'b1, REG_WDATA, w);
        bus(1'b1, REG_ADDR, w);
        bus(1'b1, REG_CTRL, 32'h1);
        k = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0);
            k++;
        end while (r[ST_DONE] !== 1'b1 && k < 300);
        chk("done", 32'h1, {31'h0, r[ST_DONE]});
        bus(1'b0, REG_RDATA, 32'h0);
        chk("rdata", (w ^ 32'h5a5a5a5a) & msk(l), r & msk(l));
        bus(1'b0, REG_WKC, 32'h0);
        chk("wkc", 32'h1, {16'h0, r[15:0]});
        chk("adp", {16'h0, (s inside {8'h04, 8'h05, 8'h06, 8'h0e}) ?
            node : w[15:0]}, {16'h0, adp});
        bus(1'b1, REG_STATUS, 32'h2);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h0, r);
    endtask : run
    // ==========================================================
    // watchdog against a hung wait
    initial begin
        #400000;
        miscompares++;
        report_and_stop();
    end
    // main sequence: reset values, refusals, then every service
    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        bus(1'b0, REG_ESM, 32'h0);
        chk("esm", 32'h1, r);
        bus(1'b0, REG_LEN, 32'h0);
        chk("len", 32'h4, r);
        bus(1'b0, 8'h30, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        bus(1'b1, REG_ASSIGN, 32'h1a00);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("asg_init", 32'h1, {31'h0, r[ST_REFUSED]});
        bus(1'b1, REG_STATUS, 32'h4);
        bus(1'b1, REG_SVC, {24'h0, SVC_LRD});
        bus(1'b1, REG_CTRL, 32'h1);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("lrd_init", 32'h2, {30'h0, r[2:1]});
        bus(1'b1, REG_STATUS, 32'h4);
        bus(1'b1, REG_ESM, 32'h2);
        bus(1'b1, REG_ASSIGN, 32'h1a01);
        bus(1'b0, REG_ASSIGN, 32'h0);
        chk("asg_preop", 32'h1a01, {16'h0, r[15:0]});
        bus(1'b1, REG_MAPSEL, 32'h1a000120);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("map_ref", 32'h1, {31'h0, r[ST_REFUSED]});
        bus(1'b1, REG_STATUS, 32'h4);
        bus(1'b1, REG_MAPSEL, 32'h10000020);
        bus(1'b1, REG_MAPSEL, 32'h1a270008);
        bus(1'b0, REG_MAPSEL, 32'h0);
        chk("map_keep", 32'h10000020, r);
        bus(1'b1, REG_STATUS, 32'h4);
        bus(1'b1, REG_ESM, 32'h8);
        node = 16'($random(seed));
        bus(1'b1, REG_NODE, {16'h0, node});
        for (int i = 0; i < 13; i++) begin
            slow <= 1'($random(seed));
            run(svcs[i], (i < 2) ? 3'(i * 4) :
                3'($unsigned($random(seed)) % 5), $random(seed));
        end
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
